/* File: rtl/bst_tap.sv */
// Purpose: Test access port with instruction, bypass, identity and boundary-scan registers.
// Assumes: The test clock is far slower than ref_clk and is found by edge detection.
// Notes:   Memory logic is never touched by this block.
// Function
// - Inputs sampled on test-clock rise; serial output and its enable launched on test-clock fall.
// - Mode-select and data inputs read high when left unconnected.
// - Exactly one register sits between data in and out, chosen by instruction.
// - Serial data enters at the MSB and leaves from the LSB.
// - Data output driven only while shifting, else high impedance; changes on fall.
// - Five rising edges with mode-select high reach the reset state from anywhere.
// - Test-port reset leaves memory operation alone, accepted during traffic.
// - Power-up resets the controller so the data output starts undriven.
// - Three-bit instruction register, loaded serially while in instruction shifting.
// - Instruction register holds the identity instruction after power-up and reset state.
// - Capture-IR loads 01 into the two low instruction bits.
// - A one-bit bypass register passes data with one stage of delay.
// - Bypass register is cleared low in Capture-DR while the bypass register is selected.
// - Boundary register has one cell per pin, including reserved unconnected pins.
// - Capture-DR loads the pin ring; Shift-DR shifts the boundary register.
// - External-test, sample and sample-floated instructions capture the pin ring.
// - Identity instruction captures a fixed 32-bit value and shifts it out.
// - A shifted instruction takes effect only on passing Update-IR.
`timescale 1ns/1ps
`default_nettype none
module bst_tap
  import bst_pkg::*;
(
  input  wire logic               ref_clk,
  input  wire logic               reset,
  input  wire logic               tck,
  input  wire logic               tms,
  input  wire logic               tms_open,
  input  wire logic               tdi,
  input  wire logic               tdi_open,
  output logic                    tdo,
  output logic                    tdo_oe_n,
  input  wire logic [BSR_LEN-1:0] ring_in,
  output logic      [BSR_LEN-1:0] ring_out,
  output logic                    ring_drive,
  output logic                    out_bus_hiz
);

  function automatic bst_state_t next_state(input bst_state_t s, input logic m);
    bst_state_t n;
    n = ST_RESET;
    unique case (s)
      ST_RESET:      n = m ? ST_RESET : ST_IDLE;
      ST_IDLE:       n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_DR:     n = m ? ST_SEL_IR : ST_CAPTURE_DR;
      ST_CAPTURE_DR: n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_SHIFT_DR:   n = m ? ST_EXIT1_DR : ST_SHIFT_DR;
      ST_EXIT1_DR:   n = m ? ST_UPDATE_DR : ST_PAUSE_DR;
      ST_PAUSE_DR:   n = m ? ST_EXIT2_DR : ST_PAUSE_DR;
      ST_EXIT2_DR:   n = m ? ST_UPDATE_DR : ST_SHIFT_DR;
      ST_UPDATE_DR:  n = m ? ST_SEL_DR : ST_IDLE;
      ST_SEL_IR:     n = m ? ST_RESET : ST_CAPTURE_IR;
      ST_CAPTURE_IR: n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_SHIFT_IR:   n = m ? ST_EXIT1_IR : ST_SHIFT_IR;
      ST_EXIT1_IR:   n = m ? ST_UPDATE_IR : ST_PAUSE_IR;
      ST_PAUSE_IR:   n = m ? ST_EXIT2_IR : ST_PAUSE_IR;
      ST_EXIT2_IR:   n = m ? ST_UPDATE_IR : ST_SHIFT_IR;
      ST_UPDATE_IR:  n = m ? ST_SEL_DR : ST_IDLE;
    endcase
    return n;
  endfunction

  // Maps an instruction to its data register; reserved codes fall to bypass.
  function automatic bst_sel_t dr_select(input logic [IR_W-1:0] op);
    bst_sel_t s;
    s = SEL_BYP;
    if (op == OP_IDCODE) begin
      s = SEL_ID;
    end else if (op == OP_EXTEST || op == OP_SAMPLE || op == OP_SAMPLE_Z) begin
      s = SEL_BSR;
    end
    return s;
  endfunction

  logic [SYNC_W-1:0]  sync_in;
  logic [SYNC_W-1:0]  sync_out;
  logic               tck_s;
  logic               tms_s;
  logic               tdi_s;
  logic [BSR_LEN-1:0] ring_s;
  logic               tck_prev_q;
  logic               tck_rise;
  logic               tck_fall;
  bst_state_t         state_q;
  bst_state_t         state_d;
  bst_sel_t           sel;
  logic [IR_W-1:0]    ir_sh_q;
  logic [IR_W-1:0]    ir_q;
  logic               byp_q;
  logic [ID_W-1:0]    id_sh_q;
  logic [BSR_LEN-1:0] bsr_q;
  logic [BSR_LEN-1:0] bsr_upd_q;
  logic               dr_out;
  logic               shifting;
  logic               tdo_q;
  logic               tdo_oe_n_q;
  logic               ring_drive_q;
  logic               out_bus_hiz_q;

  // Undriven mode-select and data pins are pulled high before sampling.
  assign sync_in = {tck, tms_open | tms, tdi_open | tdi, ring_in};

  bst_sync #(
    .W       (SYNC_W),
    .RST_VAL (SYNC_RST)
  ) u_sync (
    .ref_clk  (ref_clk),
    .reset    (reset),
    .async_in (sync_in),
    .sync_out (sync_out)
  );

  assign tck_s  = sync_out[SYNC_W-1];
  assign tms_s  = sync_out[SYNC_W-2];
  assign tdi_s  = sync_out[SYNC_W-3];
  assign ring_s = sync_out[BSR_LEN-1:0];

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tck_prev_q <= 1'b0;
    end else begin
      tck_prev_q <= tck_s;
    end
  end

  assign tck_rise = tck_s & ~tck_prev_q;
  assign tck_fall = ~tck_s & tck_prev_q;

  // Controller; the async reset is the power-up reset and touches only test logic.
  assign state_d = next_state(state_q, tms_s);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_RESET;
    end else if (tck_rise) begin
      state_q <= state_d;
    end
  end

  // Instruction shift stage and active instruction.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ir_sh_q <= IR_RST;
      ir_q    <= IR_RST;
    end else if (tck_rise) begin
      if (state_q == ST_CAPTURE_IR) begin
        ir_sh_q <= IR_CAPTURE;
      end else if (state_q == ST_SHIFT_IR) begin
        ir_sh_q <= {tdi_s, ir_sh_q[IR_W-1:1]};
      end
      if (state_d == ST_RESET) begin
        ir_q <= IR_RST;
      end else if (state_q == ST_UPDATE_IR) begin
        ir_q <= ir_sh_q;
      end
    end
  end

  assign sel = dr_select(ir_q);

  // Data registers: each captures and shifts only when it is the selected one.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      byp_q   <= 1'b0;
      id_sh_q <= ID_VALUE;
      bsr_q   <= BSR_RST;
    end else if (tck_rise) begin
      if (state_q == ST_CAPTURE_DR) begin
        unique case (sel)
          SEL_BYP: byp_q   <= 1'b0;
          SEL_ID:  id_sh_q <= ID_VALUE;
          SEL_BSR: bsr_q   <= ring_s;
        endcase
      end else if (state_q == ST_SHIFT_DR) begin
        unique case (sel)
          SEL_BYP: byp_q   <= tdi_s;
          SEL_ID:  id_sh_q <= {tdi_s, id_sh_q[ID_W-1:1]};
          SEL_BSR: bsr_q   <= {tdi_s, bsr_q[BSR_LEN-1:1]};
        endcase
      end
    end
  end

  // Update stage of the ring; the output-bus control cell is cleared on reset.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      bsr_upd_q <= BSR_RST;
    end else if (tck_rise) begin
      if (state_d == ST_RESET) begin
        bsr_upd_q[BSR_HIZ_BIT] <= 1'b0;
      end else if (state_q == ST_UPDATE_DR && sel == SEL_BSR) begin
        bsr_upd_q <= bsr_q;
      end
    end
  end

  always_comb begin
    unique case (sel)
      SEL_BYP: dr_out = byp_q;
      SEL_ID:  dr_out = id_sh_q[0];
      SEL_BSR: dr_out = bsr_q[0];
      default: dr_out = byp_q;
    endcase
  end

  assign shifting = (state_q == ST_SHIFT_IR) || (state_q == ST_SHIFT_DR);

  // Serial output and its enable launch on the falling test-clock edge.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tdo_q      <= 1'b0;
      tdo_oe_n_q <= 1'b1;
    end else if (tck_fall) begin
      tdo_q      <= (state_q == ST_SHIFT_IR) ? ir_sh_q[0] : dr_out;
      tdo_oe_n_q <= ~shifting;
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      ring_drive_q  <= 1'b0;
      out_bus_hiz_q <= 1'b0;
    end else begin
      ring_drive_q  <= (ir_q == OP_EXTEST);
      out_bus_hiz_q <= (ir_q == OP_SAMPLE_Z) ||
                       ((ir_q == OP_EXTEST) && !bsr_upd_q[BSR_HIZ_BIT]);
    end
  end

  assign tdo         = tdo_q;
  assign tdo_oe_n    = tdo_oe_n_q;
  assign ring_out    = bsr_upd_q;
  assign ring_drive  = ring_drive_q;
  assign out_bus_hiz = out_bus_hiz_q;

  // Checking logic.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  logic [2:0] tms_hi_cnt_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      tms_hi_cnt_q <= 3'h0;
    end else if (tck_rise) begin
      if (!tms_s) begin
        tms_hi_cnt_q <= 3'h0;
      end else if (tms_hi_cnt_q != 3'(TMS_HI_RST)) begin
        tms_hi_cnt_q <= tms_hi_cnt_q + 3'h1;
      end
    end
  end

  sequence s_cap_ir;
    tck_rise && state_q == ST_CAPTURE_IR;
  endsequence

  sequence s_cap_dr(bst_sel_t which);
    tck_rise && state_q == ST_CAPTURE_DR && sel == which;
  endsequence

  sequence s_shift_bsr;
    tck_rise && state_q == ST_SHIFT_DR && sel == SEL_BSR;
  endsequence

  sequence s_shift_dr(bst_sel_t which);
    tck_rise && state_q == ST_SHIFT_DR && sel == which;
  endsequence

  sequence s_rise_in(bst_state_t st);
    tck_rise && state_q == st;
  endsequence

  sequence s_fall_in(bst_state_t st);
    tck_fall && state_q == st;
  endsequence

  sequence s_fall_dr(bst_sel_t which);
    tck_fall && state_q == ST_SHIFT_DR && sel == which;
  endsequence

  tdo_stable_a: assert property (!tck_fall |=> $stable(tdo) && $stable(tdo_oe_n))
    else $error("Serial output moved away from a falling test-clock edge.");

  tdo_hiz_a: assert property (tck_fall && !shifting |=> tdo_oe_n)
    else $error("Serial output driven outside a shift state.");

  five_tms_a: assert property (tms_hi_cnt_q == 3'(TMS_HI_RST) |-> state_q == ST_RESET)
    else $error("Five high mode-select edges did not reach reset state.");

  ir_reset_a: assert property (state_q == ST_RESET |-> ir_q == OP_IDCODE)
    else $error("Instruction is not the identity code in reset state.");

  ir_capture_a: assert property (s_cap_ir |=> ir_sh_q[1:0] == 2'b01)
    else $error("Capture-IR did not load the 01 pattern.");

  byp_clear_a: assert property (s_cap_dr(SEL_BYP) |=> !byp_q)
    else $error("Bypass cell not cleared on capture.");

  id_capture_a: assert property (s_cap_dr(SEL_ID) |=> id_sh_q == ID_VALUE)
    else $error("Identity register did not capture its fixed value.");

  bsr_shift_a: assert property (s_shift_bsr |=>
    bsr_q == {$past(tdi_s), $past(bsr_q[BSR_LEN-1:1])})
    else $error("Boundary register did not shift toward its low bit.");

  ir_update_a: assert property ($changed(ir_q) |->
    $past(tck_rise) && $past(state_q) inside {ST_UPDATE_IR, ST_SEL_IR, ST_RESET})
    else $error("Instruction changed outside Update-IR or reset.");

  tdo_drive_a: assert property (tck_fall && shifting |=> !tdo_oe_n)
    else $error("Serial output not driven in a shift state.");

  tdo_ir_lsb_a: assert property (s_fall_in(ST_SHIFT_IR) |=> tdo == $past(ir_sh_q[0]))
    else $error("Serial output is not the low instruction bit.");

  tdo_bsr_lsb_a: assert property (s_fall_dr(SEL_BSR) |=> tdo == $past(bsr_q[0]))
    else $error("Serial output is not the low boundary bit.");

  tdo_id_lsb_a: assert property (s_fall_dr(SEL_ID) |=> tdo == $past(id_sh_q[0]))
    else $error("Serial output is not the low identity bit.");

  tdo_byp_a: assert property (s_fall_dr(SEL_BYP) |=> tdo == $past(byp_q))
    else $error("Serial output is not the bypass cell.");

  ir_shift_a: assert property (s_rise_in(ST_SHIFT_IR) |=>
    ir_sh_q == {$past(tdi_s), $past(ir_sh_q[IR_W-1:1])})
    else $error("Instruction register did not shift toward its low bit.");

  id_shift_a: assert property (s_shift_dr(SEL_ID) |=>
    id_sh_q == {$past(tdi_s), $past(id_sh_q[ID_W-1:1])})
    else $error("Identity register did not shift toward its low bit.");

  byp_shift_a: assert property (s_shift_dr(SEL_BYP) |=> byp_q == $past(tdi_s))
    else $error("Bypass cell did not take the serial input.");

  bsr_capture_a: assert property (s_cap_dr(SEL_BSR) |=> bsr_q == $past(ring_s))
    else $error("Boundary register did not capture the pin ring.");

  ring_update_a: assert property (s_rise_in(ST_UPDATE_DR) |=>
    sel != SEL_BSR || ring_out == $past(bsr_q))
    else $error("Ring outputs did not take the boundary register on update.");

  hiz_clear_a: assert property (tck_rise && state_d == ST_RESET |=>
    !ring_out[BSR_HIZ_BIT])
    else $error("Output-bus control cell not cleared in reset state.");

  ring_drive_a: assert property (ir_q == OP_EXTEST |=> ring_drive)
    else $error("Ring not driven while external test is active.");

endmodule
`default_nettype wire

/* File: include/bst_pkg.sv */
// Purpose: Shared constants and types of the boundary-scan test port.
// Assumes: Test clock and test pins are sampled by the 125 MHz ref_clk.
// Notes:   Opcodes and the identity value are local choices.
package bst_pkg;

  localparam int unsigned IR_W        = 3;
  localparam int unsigned ID_W        = 32;
  localparam int unsigned BSR_LEN     = 109;
  localparam int unsigned BSR_HIZ_BIT = 108;
  localparam int unsigned SYNC_W      = 3 + BSR_LEN;
  localparam int unsigned TMS_HI_RST  = 5;

  localparam logic [IR_W-1:0] OP_EXTEST   = 3'h0;
  localparam logic [IR_W-1:0] OP_IDCODE   = 3'h1;
  localparam logic [IR_W-1:0] OP_SAMPLE_Z = 3'h2;
  localparam logic [IR_W-1:0] OP_SAMPLE   = 3'h4;
  localparam logic [IR_W-1:0] OP_BYPASS   = 3'h7;
  localparam logic [IR_W-1:0] IR_CAPTURE  = 3'h1;
  localparam logic [IR_W-1:0] IR_RST      = OP_IDCODE;

  // Arbitrary identity value; bit 0 is one as the scan standard expects.
  localparam logic [ID_W-1:0] ID_VALUE = 32'h0000_0001;

  localparam logic [BSR_LEN-1:0] BSR_RST  = {BSR_LEN{1'b0}};
  localparam logic [SYNC_W-1:0]  SYNC_RST = {1'b0, 1'b1, 1'b1, {BSR_LEN{1'b0}}};

  typedef enum logic [15:0] {
    ST_RESET      = 16'h0001,
    ST_IDLE       = 16'h0002,
    ST_SEL_DR     = 16'h0004,
    ST_CAPTURE_DR = 16'h0008,
    ST_SHIFT_DR   = 16'h0010,
    ST_EXIT1_DR   = 16'h0020,
    ST_PAUSE_DR   = 16'h0040,
    ST_EXIT2_DR   = 16'h0080,
    ST_UPDATE_DR  = 16'h0100,
    ST_SEL_IR     = 16'h0200,
    ST_CAPTURE_IR = 16'h0400,
    ST_SHIFT_IR   = 16'h0800,
    ST_EXIT1_IR   = 16'h1000,
    ST_PAUSE_IR   = 16'h2000,
    ST_EXIT2_IR   = 16'h4000,
    ST_UPDATE_IR  = 16'h8000
  } bst_state_t;

  typedef enum logic [1:0] {
    SEL_BYP = 2'h0,
    SEL_ID  = 2'h1,
    SEL_BSR = 2'h2
  } bst_sel_t;

endpackage

/* File: rtl/bst_sync.sv */
// Purpose: Two-stage synchroniser for the test pins and the pin ring.
// Assumes: Inputs are asynchronous to ref_clk.
// Notes:   The first stage feeds only the second stage.
`timescale 1ns/1ps
`default_nettype none
module bst_sync
  import bst_pkg::*;
#(
  parameter int unsigned          W       = SYNC_W,
  parameter logic [SYNC_W-1:0]    RST_VAL = SYNC_RST
) (
  input  wire logic         ref_clk,
  input  wire logic         reset,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] meta_q;
  logic [W-1:0] stable_q;

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      meta_q   <= RST_VAL[W-1:0];
      stable_q <= RST_VAL[W-1:0];
    end else begin
      meta_q   <= async_in;
      stable_q <= meta_q;
    end
  end

  assign sync_out = stable_q;

endmodule
`default_nettype wire

/* File: verification/bst_host.sv */
// Purpose: Behavioural test controller that clocks the boundary-scan port.
// Assumes: One test-clock period is eight ref_clk cycles, 64 ns.
// Notes:   The test clock stands low between calls of step.
`timescale 1ns/1ps
`default_nettype none
module bst_host (
  input  wire logic ref_clk,
  output logic      tck,
  output logic      tms,
  output logic      tms_open,
  output logic      tdi,
  output logic      tdi_open,
  input  wire logic tdo,
  input  wire logic tdo_oe_n
);
  logic oe_seen;

  initial begin
    tck      = 1'b0;
    tms      = 1'b1;
    tms_open = 1'b0;
    tdi      = 1'b1;
    tdi_open = 1'b1;
    oe_seen  = 1'b1;
  end

  // Runs one test-clock period; mode and data settle while the clock is low.
  task automatic step(input logic m, input logic mo, input logic d, output logic q);
    tms      <= m;
    tms_open <= mo;
    tdi      <= d;
    tdi_open <= 1'b0;
    repeat (4) @(posedge ref_clk);
    tck <= 1'b1;
    repeat (3) @(posedge ref_clk);
    tdi_open <= 1'b1;
    tdi      <= ~d;
    @(posedge ref_clk);
    q       = tdo;
    oe_seen = tdo_oe_n;
    tck     <= 1'b0;
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_top.sv */
// Purpose: Self-checking bench of the boundary-scan test port.
// Assumes: The host model clocks the port at 64 ns per test-clock period.
// Notes:   Random stimulus is repeatable from a fixed seed.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import bst_pkg::*;
  localparam int TMO = 20000;
  logic               ref_clk, reset, tck, tms, tms_open, tdi, tdi_open, tdo, tdo_oe_n;
  logic               ring_drive, out_bus_hiz;
  logic [BSR_LEN-1:0] ring_in, ring_out;
  logic [IR_W-1:0]    ops [3] = '{OP_EXTEST, OP_SAMPLE_Z, OP_SAMPLE};
  logic [IR_W-1:0]    byp [4] = '{OP_BYPASS, 3'h3, 3'h5, 3'h6};
  int                 fails, n_checks, cycles;

  bst_tap u_bst_tap (.ref_clk, .reset, .tck, .tms, .tms_open, .tdi, .tdi_open, .tdo,
    .tdo_oe_n, .ring_in, .ring_out, .ring_drive, .out_bus_hiz);
  bst_host u_bst_host (.ref_clk, .tck, .tms, .tms_open, .tdi, .tdi_open, .tdo, .tdo_oe_n);

  initial begin
    ref_clk = 1'b0;
    forever #4 ref_clk = ~ref_clk;
  end

  task automatic complete_run();
    $display("Checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask

  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == TMO) begin
      fails++;
      complete_run();
    end
  end

  task automatic chk(input string what, input logic [127:0] exp, input logic [127:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  function automatic logic [BSR_LEN-1:0] rnd();
    logic [127:0] r;
    r = {$urandom(), $urandom(), $urandom(), $urandom()};
    return r[BSR_LEN-1:0];
  endfunction

  // Steps the controller with mode-select bits taken from s, bit 0 first.
  task automatic walk(input logic [7:0] s, input int n);
    logic q;
    for (int i = 0; i < n; i++) u_bst_host.step(s[i], 1'b0, 1'b1, q);
  endtask

  // Full scan from Run-Test/Idle back to Run-Test/Idle.
  task automatic scan(input logic ir, input int n, input logic [BSR_LEN-1:0] din,
                      output logic [BSR_LEN-1:0] dout);
    logic q;
    dout = '0;
    walk(ir ? 8'h03 : 8'h01, ir ? 4 : 3);
    for (int i = 0; i < n; i++) begin
      u_bst_host.step(i == n - 1, 1'b0, din[i], q);
      dout[i] = q;
      chk("tdo_oe_n in shift", 1'b0, u_bst_host.oe_seen);
    end
    u_bst_host.step(1'b1, 1'b0, 1'b1, q);
    chk("tdo_oe_n after shift", 1'b1, u_bst_host.oe_seen);
    u_bst_host.step(1'b0, 1'b0, 1'b1, q);
  endtask

  task automatic ir_load(input logic [IR_W-1:0] op);
    logic [BSR_LEN-1:0] o;
    scan(1'b1, IR_W, BSR_LEN'(op), o);
    chk("ir capture", IR_CAPTURE, o[IR_W-1:0]);
  endtask

  // Mode-select high five times, or left open with the pin driven low.
  task automatic tap_reset(input logic open);
    logic q;
    repeat (TMS_HI_RST) u_bst_host.step(~open, open, 1'b0, q);
    u_bst_host.step(1'b0, 1'b0, 1'b0, q);
  endtask

  task automatic id_check();
    logic [BSR_LEN-1:0] o;
    scan(1'b0, ID_W, rnd(), o);
    chk("identity value", ID_VALUE, o[ID_W-1:0]);
  endtask

  initial begin
    logic [BSR_LEN-1:0] o, p;
    reset    = 1'b1;
    ring_in  = '0;
    fails    = 0;
    n_checks = 0;
    cycles   = 0;
    void'($urandom(62379));
    repeat (12) @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("tdo_oe_n after power up", 1'b1, tdo_oe_n);
    chk("ring_drive after power up", 1'b0, ring_drive);
    tap_reset(1'b0);
    id_check();
    $display("Test identity done");
    foreach (ops[k]) begin
      ir_load(ops[k]);
      ring_in <= rnd();
      p = rnd();
      p[BSR_HIZ_BIT] = ~k[0];
      scan(1'b0, BSR_LEN, p, o);
      @(posedge ref_clk);
      chk("ring capture", ring_in, o);
      chk("ring_out", p, ring_out);
      chk("ring_drive", ops[k] == OP_EXTEST, ring_drive);
      chk("out_bus_hiz", ops[k] == OP_SAMPLE_Z || (ops[k] == OP_EXTEST && !p[BSR_HIZ_BIT]),
          out_bus_hiz);
      $display("Test ring opcode %0d done", ops[k]);
    end
    foreach (byp[k]) begin
      ir_load(byp[k]);
      p = rnd();
      scan(1'b0, 8, p, o);
      chk("bypass stream", {p[6:0], 1'b0}, o[7:0]);
    end
    $display("Test bypass done");
    ir_load(OP_EXTEST);
    walk(8'h43, 8);
    chk("ring_drive before update", 1'b1, ring_drive);
    tap_reset(1'b1);
    chk("ring_drive after open reset", 1'b0, ring_drive);
    id_check();
    ir_load(OP_EXTEST);
    @(posedge ref_clk);
    chk("out_bus_hiz after reset", 1'b1, out_bus_hiz);
    $display("Test pending instruction done");
    walk(8'h01, 3);
    tap_reset(1'b0);
    id_check();
    walk(8'h01, 3);
    repeat (6) @(posedge ref_clk);
    chk("tdo_oe_n in shift", 1'b0, tdo_oe_n);
    reset <= 1'b1;
    @(posedge ref_clk);
    reset <= 1'b0;
    repeat (4) @(posedge ref_clk);
    chk("tdo_oe_n after reset", 1'b1, tdo_oe_n);
    walk(8'h00, 1);
    id_check();
    $display("Test reset from shift done");
    complete_run();
  end
endmodule
`default_nettype wire
